// >>> verilog/usb_ep_defines.vh
`ifndef USB_EP_DEFINES_VH
`define USB_EP_DEFINES_VH

// processor i/o addresses
`define ADDR_CTRL_MODE      8'h44
`define ADDR_DATA1_MODE     8'h45
`define ADDR_DATA2_MODE     8'h46
`define ADDR_BUF0_BASE      8'h50
`define ADDR_BUF1_BASE      8'h58
`define ADDR_BUF2_BASE      8'h60
`define ADDR_BUF_MASK       8'hF8

// control endpoint mode register fields
`define CM_SETUP_BIT        7
`define CM_IN_BIT           6
`define CM_OUT_BIT          5
`define CM_ACKD_BIT         4
`define MODE_MSB            3
`define MODE_LSB            0

// data endpoint mode register fields
`define DM_STALL_BIT        7
`define DM_NAK_IE_BIT       5
`define DM_ACKD_BIT         4

`define MODE_REG_RESET      8'h00

// mode encodings
`define MODE_DISABLE        4'h0
`define MODE_NAK_IN_OUT     4'h1
`define MODE_STATUS_OUT     4'h2
`define MODE_STALL_IN_OUT   4'h3
`define MODE_STATUS_IN      4'h6
`define MODE_ACK_OUT_STS_IN 4'hB
`define MODE_ACK_IN_STS_OUT 4'hF
`define MODE_NAK_OUT        4'h8
`define MODE_ACK_OUT        4'h9
`define MODE_NAK_IN         4'hC
`define MODE_ACK_IN         4'hD

// token kinds from the serial engine
`define TOK_SETUP           2'h0
`define TOK_IN              2'h1
`define TOK_OUT             2'h2

// handshake answers
`define RESP_IGNORE         3'h0
`define RESP_ACK            3'h1
`define RESP_NAK            3'h2
`define RESP_STALL          3'h3
`define RESP_TX_COUNT       3'h4
`define RESP_TX_ZERO        3'h5
`define RESP_CHECK          3'h6

`endif

// >>> verilog/ep_buffer.v
`timescale 1ns/1ps
// one endpoint's byte buffer, cpu and engine ports
module ep_buffer
#(
    parameter DEPTH  = 8,
    parameter AW     = 3
)
(
    input  wire          ref_clk,
    input  wire          ce,
    input  wire          cpu_we,
    input  wire [AW-1:0] cpu_idx,
    input  wire [7:0]    cpu_wdata,
    output wire [7:0]    cpu_rdata,
    input  wire          eng_we,
    input  wire [AW-1:0] eng_idx,
    input  wire [7:0]    eng_wdata,
    output wire [7:0]    eng_rdata
);
    // no reset: contents are undefined after reset
    reg [7:0] mem [0:DEPTH-1];

    // engine wins same-byte collision
    always @(posedge ref_clk)
    begin
        if (ce)
        begin
            if (eng_we)
                mem[eng_idx] <= eng_wdata;
            if (cpu_we && !(eng_we && eng_idx == cpu_idx))
                mem[cpu_idx] <= cpu_wdata;
        end
    end

    assign cpu_rdata = mem[cpu_idx];
    assign eng_rdata = mem[eng_idx];
endmodule // ep_buffer

// >>> verilog/skid_buffer.v
`timescale 1ns/1ps
// two-entry buffer; a stalled receiver loses no word
module skid_buffer
#(
    parameter WIDTH = 8
)
(
    input  wire             ref_clk,
    input  wire             nrst,
    input  wire             ce,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] slot_reg [0:1];
    reg             rd_ptr_reg;
    reg             wr_ptr_reg;
    reg [1:0]       count_reg;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = slot_reg[rd_ptr_reg];

    always @(posedge ref_clk)
    begin
        if (ce && push)
            slot_reg[wr_ptr_reg] <= in_data;
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end
        else if (ce)
        begin
            if (push)
                wr_ptr_reg <= ~wr_ptr_reg;
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            if (push && !pop)
                count_reg <= count_reg + 2'h1;
            else if (pop && !push)
                count_reg <= count_reg - 2'h1;
        end
    end
endmodule // skid_buffer

// >>> verilog/usb_endpoint_mode_and_buffers.v
// Behaviour
// - engine sets setup-received flag on each valid SETUP packet
// - setup flag held high, unclearable by processor writes, from SETUP data until control-write data ends
// - while setup flag is 1, processor writes to control buffer are blocked
// - unblocked processor write to control mode clears its four status flags
// - both data mode registers share one update strobe; engine write blocks other
// - engine mode write beats a simultaneous processor write
// - three 8-byte endpoint buffers, each for IN and OUT
// - OUT payload stored in buffer; IN bytes read from buffer
// - buffer contents not reset
// - buffers reached only through processor i/o space
// - control buffer at i/o 0x50 to 0x57, one byte each
// - engine write to control mode locks it until processor reads it
// - processor write to control mode clears upper four bits whatever the data
// - control modes: 0000 ignore, 0001 NAK, 0011 stall, 1111 send count
// - data mode 1001 goes 1000 after OUT ACK; 1101 goes 1100 after IN ACK
`timescale 1ns/1ps
`include "usb_ep_defines.vh"
module usb_endpoint_mode_and_buffers
#(
    parameter BUF_DEPTH = 8,
    parameter BUF_AW    = 3
)
(
    input  wire              ref_clk,
    input  wire              nrst,
    input  wire              ce,
    // cpu i/o
    input  wire [7:0]        io_addr,
    input  wire              io_wr,
    input  wire              io_rd,
    input  wire [7:0]        io_wdata,
    output reg  [7:0]        io_rdata,
    // engine tokens
    input  wire              tok_valid,
    input  wire [1:0]        tok_kind,
    input  wire [1:0]        tok_ep,
    output reg  [2:0]        tok_resp,
    input  wire              setup_data_start,
    input  wire              ctrl_write_data_end,
    input  wire              out_last_packet,
    input  wire              ack_done,
    input  wire [1:0]        ack_ep,
    input  wire              in_acked,
    // engine buffer port
    input  wire              eng_we,
    input  wire [1:0]        eng_ep,
    input  wire [BUF_AW-1:0] eng_idx,
    input  wire [7:0]        eng_wdata,
    output wire              eng_in_valid,
    input  wire              eng_in_ready,
    output wire [7:0]        eng_in_data,
    input  wire              eng_rd_req,
    output wire              eng_rd_ack,
    // engine mode writes
    input  wire              eng_mode_we,
    input  wire [1:0]        eng_mode_ep,
    input  wire [7:0]        eng_mode_data,
    output wire [3:0]        control_mode,
    output reg               nak_irq
);
    reg  [7:0] control_endpoint_mode_reg;
    reg  [7:0] data_endpoint_one_mode_reg;
    reg  [7:0] data_endpoint_two_mode_reg;
    reg        ctrl_lock_reg;
    reg        setup_hold_reg;

    wire sel_ctrl = (io_addr == `ADDR_CTRL_MODE);
    wire sel_d1   = (io_addr == `ADDR_DATA1_MODE);
    wire sel_d2   = (io_addr == `ADDR_DATA2_MODE);
    wire [7:0] buf_tag = io_addr & `ADDR_BUF_MASK;
    // i/o space only, never data memory
    wire sel_b0   = (buf_tag == `ADDR_BUF0_BASE);
    wire sel_b1   = (buf_tag == `ADDR_BUF1_BASE);
    wire sel_b2   = (buf_tag == `ADDR_BUF2_BASE);
    wire [BUF_AW-1:0] cpu_idx = io_addr[BUF_AW-1:0];

    wire setup_flag = control_endpoint_mode_reg[`CM_SETUP_BIT];
    wire [3:0] d1_mode = data_endpoint_one_mode_reg[`MODE_MSB:`MODE_LSB];
    wire [3:0] d2_mode = data_endpoint_two_mode_reg[`MODE_MSB:`MODE_LSB];
    assign control_mode = control_endpoint_mode_reg[`MODE_MSB:`MODE_LSB];

    // one strobe: engine data-mode write blocks firmware on both
    wire eng_data_mode_we = eng_mode_we && (eng_mode_ep != 2'h0);
    wire update_strobe    = eng_data_mode_we;
    wire cpu_ctrl_we = io_wr && sel_ctrl && !ctrl_lock_reg;
    wire eng_ctrl_we = eng_mode_we && (eng_mode_ep == 2'h0);

    // control buffer closed while setup pending
    wire cpu_b0_we = io_wr && sel_b0 && !setup_flag;
    wire cpu_b1_we = io_wr && sel_b1;
    wire cpu_b2_we = io_wr && sel_b2;

    wire [7:0] b0_rd;
    wire [7:0] b1_rd;
    wire [7:0] b2_rd;
    wire [7:0] e0_rd;
    wire [7:0] e1_rd;
    wire [7:0] e2_rd;

    // three buffers, both directions
    ep_buffer #(.DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_buf0
    (
        .ref_clk   (ref_clk),
        .ce        (ce),
        .cpu_we    (cpu_b0_we),
        .cpu_idx   (cpu_idx),
        .cpu_wdata (io_wdata),
        .cpu_rdata (b0_rd),
        .eng_we    (eng_we && eng_ep == 2'h0),
        .eng_idx   (eng_idx),
        .eng_wdata (eng_wdata),
        .eng_rdata (e0_rd)
    );
    ep_buffer #(.DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_buf1
    (
        .ref_clk   (ref_clk),
        .ce        (ce),
        .cpu_we    (cpu_b1_we),
        .cpu_idx   (cpu_idx),
        .cpu_wdata (io_wdata),
        .cpu_rdata (b1_rd),
        .eng_we    (eng_we && eng_ep == 2'h1),
        .eng_idx   (eng_idx),
        .eng_wdata (eng_wdata),
        .eng_rdata (e1_rd)
    );
    ep_buffer #(.DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_buf2
    (
        .ref_clk   (ref_clk),
        .ce        (ce),
        .cpu_we    (cpu_b2_we),
        .cpu_idx   (cpu_idx),
        .cpu_wdata (io_wdata),
        .cpu_rdata (b2_rd),
        .eng_we    (eng_we && eng_ep == 2'h2),
        .eng_idx   (eng_idx),
        .eng_wdata (eng_wdata),
        .eng_rdata (e2_rd)
    );

    // IN bytes via 2-entry buffer: stalls lose none
    reg  [7:0] eng_sel_rd;
    always @*
    begin
        case (eng_ep)
            2'h0:    eng_sel_rd = e0_rd;
            2'h1:    eng_sel_rd = e1_rd;
            2'h2:    eng_sel_rd = e2_rd;
            default: eng_sel_rd = 8'h00;
        endcase
    end

    skid_buffer #(.WIDTH(8)) u_in_path
    (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .ce        (ce),
        .in_valid  (eng_rd_req),
        .in_ready  (eng_rd_ack),
        .in_data   (eng_sel_rd),
        .out_valid (eng_in_valid),
        .out_ready (eng_in_ready),
        .out_data  (eng_in_data)
    );

    // token answers
    function [2:0] ctrl_answer;
        input [3:0] m;
        input [1:0] k;
        begin
            case (m)
                `MODE_NAK_IN_OUT:
                    ctrl_answer = (k == `TOK_SETUP) ? `RESP_ACK : `RESP_NAK;
                `MODE_STATUS_OUT:
                    ctrl_answer = (k == `TOK_SETUP) ? `RESP_ACK :
                                  (k == `TOK_IN) ? `RESP_STALL : `RESP_CHECK;
                `MODE_STALL_IN_OUT:
                    ctrl_answer = (k == `TOK_SETUP) ? `RESP_ACK : `RESP_STALL;
                `MODE_STATUS_IN:
                    ctrl_answer = (k == `TOK_SETUP) ? `RESP_ACK :
                                  (k == `TOK_IN) ? `RESP_TX_ZERO : `RESP_STALL;
                `MODE_ACK_OUT_STS_IN:
                    ctrl_answer = (k == `TOK_IN) ? `RESP_TX_ZERO : `RESP_ACK;
                `MODE_ACK_IN_STS_OUT:
                    ctrl_answer = (k == `TOK_SETUP) ? `RESP_ACK :
                                  (k == `TOK_IN) ? `RESP_TX_COUNT : `RESP_CHECK;
                default:
                    ctrl_answer = `RESP_IGNORE;
            endcase
        end
    endfunction

    function [2:0] data_answer;
        input [7:0] r;
        input [1:0] k;
        begin
            case (r[`MODE_MSB:`MODE_LSB])
                `MODE_NAK_OUT:
                    data_answer = (k == `TOK_OUT) ? `RESP_NAK : `RESP_IGNORE;
                `MODE_ACK_OUT:
                    data_answer = (k != `TOK_OUT) ? `RESP_IGNORE :
                        r[`DM_STALL_BIT] ? `RESP_STALL : `RESP_ACK;
                `MODE_NAK_IN:
                    data_answer = (k == `TOK_IN) ? `RESP_NAK : `RESP_IGNORE;
                `MODE_ACK_IN:
                    data_answer = (k != `TOK_IN) ? `RESP_IGNORE :
                        r[`DM_STALL_BIT] ? `RESP_STALL : `RESP_TX_COUNT;
                default:
                    data_answer = `RESP_IGNORE;
            endcase
        end
    endfunction

    reg [2:0] resp_next;
    reg       nak_hit;
    always @*
    begin
        resp_next = `RESP_IGNORE;
        nak_hit   = 1'b0;
        if (tok_valid)
        begin
            case (tok_ep)
                2'h0:    resp_next = ctrl_answer(control_mode, tok_kind);
                2'h1:    resp_next = data_answer(data_endpoint_one_mode_reg, tok_kind);
                2'h2:    resp_next = data_answer(data_endpoint_two_mode_reg, tok_kind);
                default: resp_next = `RESP_IGNORE;
            endcase
            case (tok_ep)
                2'h1:    nak_hit = (resp_next == `RESP_NAK) &&
                                   data_endpoint_one_mode_reg[`DM_NAK_IE_BIT];
                2'h2:    nak_hit = (resp_next == `RESP_NAK) &&
                                   data_endpoint_two_mode_reg[`DM_NAK_IE_BIT];
                default: nak_hit = 1'b0;
            endcase
        end
    end

    // lost writes show only on read-back
    wire cpu_d1_we = io_wr && sel_d1 && !update_strobe;
    wire cpu_d2_we = io_wr && sel_d2 && !update_strobe;

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            control_endpoint_mode_reg  <= `MODE_REG_RESET;
            data_endpoint_one_mode_reg <= `MODE_REG_RESET;
            data_endpoint_two_mode_reg <= `MODE_REG_RESET;
            ctrl_lock_reg              <= 1'b0;
            setup_hold_reg             <= 1'b0;
            tok_resp                   <= `RESP_IGNORE;
            nak_irq                    <= 1'b0;
        end
        else if (ce)
        begin
            tok_resp <= resp_next;
            nak_irq  <= nak_hit;

            // hold window for the setup flag
            if (setup_data_start)
                setup_hold_reg <= 1'b1;
            else if (ctrl_write_data_end)
                setup_hold_reg <= 1'b0;

            // engine first, then unlocked firmware
            if (eng_ctrl_we)
            begin
                control_endpoint_mode_reg <= eng_mode_data;
                ctrl_lock_reg             <= 1'b1;
            end
            else
            begin
                if (io_rd && sel_ctrl)
                    ctrl_lock_reg <= 1'b0;
                if (cpu_ctrl_we)
                    // data's upper bits are discarded
                    control_endpoint_mode_reg <= {4'h0, io_wdata[`MODE_MSB:`MODE_LSB]};
                // hardware sets beat same-cycle clear
                if (setup_hold_reg || setup_data_start ||
                    (tok_valid && tok_ep == 2'h0 && tok_kind == `TOK_SETUP))
                    control_endpoint_mode_reg[`CM_SETUP_BIT] <= 1'b1;
                if (in_acked)
                    control_endpoint_mode_reg[`CM_IN_BIT] <= 1'b1;
                if (out_last_packet)
                    control_endpoint_mode_reg[`CM_OUT_BIT] <= 1'b1;
                if (ack_done && ack_ep == 2'h0)
                    control_endpoint_mode_reg[`CM_ACKD_BIT] <= 1'b1;
            end

            // engine write wins, blocks firmware
            if (eng_data_mode_we && eng_mode_ep == 2'h1)
                data_endpoint_one_mode_reg <= eng_mode_data;
            else
            begin
                if (cpu_d1_we)
                    data_endpoint_one_mode_reg <= {io_wdata[7:5], 1'b0, io_wdata[3:0]};
                if (ack_done && ack_ep == 2'h1)
                begin
                    data_endpoint_one_mode_reg[`DM_ACKD_BIT] <= 1'b1;
                    if (d1_mode == `MODE_ACK_OUT)
                        data_endpoint_one_mode_reg[`MODE_MSB:`MODE_LSB] <= `MODE_NAK_OUT;
                    else if (d1_mode == `MODE_ACK_IN)
                        data_endpoint_one_mode_reg[`MODE_MSB:`MODE_LSB] <= `MODE_NAK_IN;
                end
            end
            if (eng_data_mode_we && eng_mode_ep == 2'h2)
                data_endpoint_two_mode_reg <= eng_mode_data;
            else
            begin
                if (cpu_d2_we)
                    data_endpoint_two_mode_reg <= {io_wdata[7:5], 1'b0, io_wdata[3:0]};
                if (ack_done && ack_ep == 2'h2)
                begin
                    data_endpoint_two_mode_reg[`DM_ACKD_BIT] <= 1'b1;
                    if (d2_mode == `MODE_ACK_OUT)
                        data_endpoint_two_mode_reg[`MODE_MSB:`MODE_LSB] <= `MODE_NAK_OUT;
                    else if (d2_mode == `MODE_ACK_IN)
                        data_endpoint_two_mode_reg[`MODE_MSB:`MODE_LSB] <= `MODE_NAK_IN;
                end
            end
        end
    end

    // unmapped reads zero
    always @*
    begin
        io_rdata = 8'h00;
        if (sel_ctrl)
            io_rdata = control_endpoint_mode_reg;
        else if (sel_d1)
            io_rdata = data_endpoint_one_mode_reg;
        else if (sel_d2)
            io_rdata = data_endpoint_two_mode_reg;
        else if (sel_b0)
            io_rdata = b0_rd;
        else if (sel_b1)
            io_rdata = b1_rd;
        else if (sel_b2)
            io_rdata = b2_rd;
    end
endmodule // usb_endpoint_mode_and_buffers

// >>> test/usb_ep_checker_sva.sv
`timescale 1ns/1ps
`include "usb_ep_defines.vh"
module usb_ep_checker
(
    input wire       ref_clk,
    input wire       nrst,
    input wire       ce,
    input wire [7:0] io_addr,
    input wire       io_wr,
    input wire       io_rd,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata,
    input wire       tok_valid,
    input wire [1:0] tok_kind,
    input wire [1:0] tok_ep,
    input wire [2:0] tok_resp,
    input wire       setup_data_start,
    input wire       out_last_packet,
    input wire       ack_done,
    input wire [1:0] ack_ep,
    input wire       in_acked,
    input wire       eng_in_valid,
    input wire       eng_in_ready,
    input wire [7:0] eng_in_data,
    input wire       eng_mode_we,
    input wire [1:0] eng_mode_ep,
    input wire [7:0] eng_mode_data,
    input wire [3:0] control_mode,
    input wire       nak_irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst || !ce);
    // quiet cycles only: events lock or set flags
    wire hw_evt = tok_valid | setup_data_start | out_last_packet | ack_done | in_acked
                  | eng_mode_we;
    wire ctl0   = tok_valid && tok_ep == 2'h0 && tok_kind != `TOK_SETUP;
    sequence unlocked_write;
        io_rd && io_addr == `ADDR_CTRL_MODE && !hw_evt ##1 !io_wr && !hw_evt
            ##1 io_wr && io_addr == `ADDR_CTRL_MODE && !hw_evt;
    endsequence
    sequence data_ack(m);
        ack_done && ack_ep != 2'h0 && io_addr == (`ADDR_CTRL_MODE + {6'h00, ack_ep})
            && io_rdata[3:0] == m && !eng_mode_we && !io_wr;
    endsequence
    AST_RESP_IDLE: assert property (!tok_valid |=> tok_resp == `RESP_IGNORE)
        else $error("answer without token");
    AST_CTRL_NAK: assert property (
        ctl0 && control_mode == `MODE_NAK_IN_OUT |=> tok_resp == `RESP_NAK)
        else $error("control nak mode wrong answer");
    AST_CTRL_STALL: assert property (
        ctl0 && control_mode == `MODE_STALL_IN_OUT |=> tok_resp == `RESP_STALL)
        else $error("control stall mode wrong answer");
    AST_NAK_IRQ: assert property (
        nak_irq |-> tok_resp == `RESP_NAK && $past(tok_ep) != 2'h0)
        else $error("nak interrupt without data endpoint nak");
    AST_ENG_MODE: assert property (
        eng_mode_we && eng_mode_ep == 2'h0
        |=> {4'h0, control_mode} == ($past(eng_mode_data) & 8'h0F))
        else $error("engine mode write not taken");
    AST_CTRL_WRITE: assert property (
        unlocked_write |=> {4'h0, control_mode} == ($past(io_wdata) & 8'h0F))
        else $error("unlocked control mode write not taken");
    AST_ACK_OUT: assert property (
        data_ack(`MODE_ACK_OUT) ##1 $stable(io_addr) |-> io_rdata[3:0] == `MODE_NAK_OUT)
        else $error("ack out mode did not fall back");
    AST_ACK_IN: assert property (
        data_ack(`MODE_ACK_IN) ##1 $stable(io_addr) |-> io_rdata[3:0] == `MODE_NAK_IN)
        else $error("ack in mode did not fall back");
    AST_INBUF_HOLD: assert property (
        eng_in_valid && !eng_in_ready |=> eng_in_valid && $stable(eng_in_data))
        else $error("stalled in byte lost or changed");
endmodule // usb_ep_checker
bind usb_endpoint_mode_and_buffers usb_ep_checker usb_ep_checker_i (.*);

// >>> test/usb_host_model.sv
`timescale 1ns/1ps
// host sink: random stalls, or held
module usb_host_model
(
    input  wire       ref_clk,
    input  wire       nrst,
    input  wire       hold,
    input  wire       in_valid,
    output wire       in_ready,
    input  wire [7:0] in_data,
    output reg        got,
    output reg  [7:0] got_data
);
    reg [7:0] stall_reg;
    assign in_ready = !hold && stall_reg[0];
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stall_reg <= 8'hA5;
            got       <= 1'b0;
            got_data  <= 8'h00;
        end
        else
        begin
            stall_reg <= {stall_reg[6:0], stall_reg[7] ^ stall_reg[5] ^ stall_reg[4]};
            got       <= in_valid && in_ready;
            got_data  <= in_data;
        end
    end
endmodule // usb_host_model

// >>> test/testbench.sv
`timescale 1ns/1ps
`include "usb_ep_defines.vh"
module testbench;
    reg         ref_clk, nrst, io_wr, io_rd, tok_valid, ack_done, in_acked, eng_we;
    reg         setup_data_start, ctrl_write_data_end, out_last_packet, eng_mode_we;
    reg         eng_rd_req, hold, ce;
    reg  [7:0]  io_addr, io_wdata, eng_wdata, eng_mode_data;
    reg  [1:0]  tok_kind, tok_ep, ack_ep, eng_ep, eng_mode_ep;
    reg  [2:0]  eng_idx;
    wire [7:0]  io_rdata, eng_in_data, got_data;
    wire [2:0]  tok_resp;
    wire [3:0]  control_mode;
    wire        eng_in_valid, eng_in_ready, eng_rd_ack, nak_irq, got;
    reg  [31:0] lfsr;
    reg  [7:0]  exp_buf [0:23];
    reg  [8:0]  mt [0:9];
    integer     fails, checked, cycles, pidx, i, n;
    usb_endpoint_mode_and_buffers usb_endpoint_mode_and_buffers_i (.*);
    usb_host_model usb_host_model_i (.ref_clk, .nrst, .hold, .in_valid(eng_in_valid),
        .in_ready(eng_in_ready), .in_data(eng_in_data), .got, .got_data);
    function [31:0] nxt(input [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string w, input [7:0] e, input [7:0] g);
        checked = checked + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task rd(input [7:0] a, input [7:0] e, input [7:0] m);
        @(posedge ref_clk);
        io_rd   <= 1'b1;
        io_addr <= a;
        @(negedge ref_clk);
        chk("io_rdata", e, io_rdata & m);
        @(posedge ref_clk);
        io_rd <= 1'b0;
    endtask
    // m: start, end, out, ack, in, engine mode
    task ev(input [5:0] m, input [1:0] ep, input [7:0] d, input w, input [7:0] a,
            input [7:0] wd);
        @(posedge ref_clk);
        {setup_data_start, ctrl_write_data_end, out_last_packet, ack_done, in_acked,
         eng_mode_we} <= m;
        ack_ep        <= ep;
        eng_mode_ep   <= ep;
        eng_mode_data <= d;
        io_wr         <= w;
        io_addr       <= a;
        io_wdata      <= wd;
        @(posedge ref_clk);
        {setup_data_start, ctrl_write_data_end, out_last_packet, ack_done, in_acked,
         eng_mode_we} <= 6'h00;
        io_wr <= 1'b0;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        ev(6'h00, 2'h0, 8'h00, 1'b1, a, d);
    endtask
    task tok(input [1:0] ep, input [1:0] k, input [2:0] e, input irq);
        @(posedge ref_clk);
        tok_valid <= 1'b1;
        tok_ep    <= ep;
        tok_kind  <= k;
        @(posedge ref_clk);
        tok_valid <= 1'b0;
        @(negedge ref_clk);
        chk("tok_resp", {5'h00, e}, {5'h00, tok_resp});
        chk("nak_irq", {7'h00, irq}, {7'h00, nak_irq});
    endtask
    task test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 4000)
        begin
            fails = fails + 1;
            test_done;
        end
    end
    always @(negedge ref_clk)
    begin
        if (got === 1'b1)
        begin
            chk("eng_in_data", exp_buf[pidx], got_data);
            pidx = pidx + 1;
        end
    end
    initial
    begin
        {nrst, io_wr, io_rd, tok_valid, ack_done, in_acked, eng_we, setup_data_start,
         ctrl_write_data_end, out_last_packet, eng_mode_we, eng_rd_req, io_addr, io_wdata,
         eng_wdata, eng_mode_data, tok_kind, tok_ep, ack_ep, eng_ep, eng_mode_ep, eng_idx} = 57'h0;
        {fails, checked, cycles, pidx, hold, ce, lfsr} = {96'h10, 2'h3, 32'h005616C7};
        mt = '{{`MODE_DISABLE, `TOK_IN, `RESP_IGNORE}, {`MODE_NAK_IN_OUT, `TOK_IN, `RESP_NAK},
               {`MODE_NAK_IN_OUT, `TOK_OUT, `RESP_NAK}, {`MODE_STALL_IN_OUT, `TOK_OUT, `RESP_STALL},
               {`MODE_ACK_IN_STS_OUT, `TOK_IN, `RESP_TX_COUNT}, {`MODE_STATUS_IN, `TOK_IN, `RESP_TX_ZERO},
               {`MODE_STATUS_OUT, `TOK_IN, `RESP_STALL}, {`MODE_STATUS_OUT, `TOK_OUT, `RESP_CHECK},
               {`MODE_ACK_OUT_STS_IN, `TOK_SETUP, `RESP_ACK}, {4'h5, `TOK_IN, `RESP_IGNORE}};
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
            rd(8'h44 + i[7:0], 8'h00, 8'hFF);
        for (i = 0; i < 24; i = i + 1)
        begin
            lfsr = nxt(lfsr);
            exp_buf[i] = lfsr[7:0];
            wr(8'h50 + i[7:0], lfsr[7:0]);
        end
        for (i = 0; i < 24; i = i + 1)
            rd(8'h50 + i[7:0], exp_buf[i], 8'hFF);
        ev(6'h0E, 2'h0, 8'h00, 1'b0, 8'h44, 8'h00);
        rd(8'h44, 8'h70, 8'hFF);
        wr(8'h44, 8'hF3);
        rd(8'h44, 8'h03, 8'hFF);
        ev(6'h01, 2'h0, 8'h01, 1'b0, 8'h44, 8'h00);
        wr(8'h44, 8'h06);
        rd(8'h44, 8'h01, 8'hFF);
        wr(8'h44, 8'h06);
        rd(8'h44, 8'h06, 8'hFF);
        for (i = 0; i < 10; i = i + 1)
        begin
            wr(8'h44, {4'h0, mt[i][8:5]});
            rd(8'h44, {4'h0, mt[i][8:5]}, 8'h0F);
            tok(2'h0, mt[i][4:3], mt[i][2:0], 1'b0);
        end
        wr(8'h44, {4'h0, `MODE_ACK_OUT_STS_IN});
        rd(8'h44, 8'h0B, 8'hFF);
        tok(2'h0, `TOK_SETUP, `RESP_ACK, 1'b0);
        rd(8'h44, 8'h80, 8'h80);
        wr(8'h50, 8'h5A);
        rd(8'h50, exp_buf[0], 8'hFF);
        ev(6'h20, 2'h0, 8'h00, 1'b1, 8'h44, 8'h0B);
        rd(8'h44, 8'h80, 8'h80);
        ev(6'h10, 2'h0, 8'h00, 1'b0, 8'h44, 8'h00);
        rd(8'h44, 8'h80, 8'h80);
        wr(8'h44, 8'h0B);
        rd(8'h44, 8'h0B, 8'hFF);
        wr(8'h50, 8'h5A);
        rd(8'h50, 8'h5A, 8'hFF);
        for (n = 1; n < 3; n = n + 1)
        begin
            wr(8'h44 + n[7:0], 8'h09);
            ev(6'h04, n[1:0], 8'h00, 1'b0, 8'h44 + n[7:0], 8'h00);
            rd(8'h44 + n[7:0], 8'h18, 8'hFF);
            wr(8'h44 + n[7:0], 8'h2C);
            tok(n[1:0], `TOK_IN, `RESP_NAK, 1'b1);
            wr(8'h44 + n[7:0], 8'h8D);
            tok(n[1:0], `TOK_IN, `RESP_STALL, 1'b0);
            wr(8'h44 + n[7:0], 8'h0D);
            tok(n[1:0], `TOK_IN, `RESP_TX_COUNT, 1'b0);
            ev(6'h04, n[1:0], 8'h00, 1'b0, 8'h44 + n[7:0], 8'h00);
            rd(8'h44 + n[7:0], 8'h1C, 8'hFF);
        end
        ev(6'h01, 2'h1, 8'h08, 1'b1, 8'h46, 8'h0C);
        rd(8'h45, 8'h08, 8'hFF);
        rd(8'h46, 8'h1C, 8'hFF);
        wr(8'h46, 8'h0C);
        rd(8'h46, 8'h0C, 8'hFF);
        ce <= 1'b0;
        wr(8'h46, 8'h55);
        rd(8'h46, 8'h0C, 8'hFF);
        ce <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
        begin
            @(posedge ref_clk);
            lfsr = nxt(lfsr);
            exp_buf[16 + i] = lfsr[7:0];
            eng_we    <= 1'b1;
            eng_ep    <= 2'h2;
            eng_idx   <= i[2:0];
            eng_wdata <= lfsr[7:0];
        end
        @(posedge ref_clk);
        eng_we <= 1'b0;
        rd(8'h63, exp_buf[19], 8'hFF);
        for (i = 0; i < 8; i = i + 1)
        begin
            @(posedge ref_clk);
            eng_rd_req <= 1'b1;
            eng_idx    <= i[2:0];
            @(negedge ref_clk);
            if (i == 2)
            begin
                chk("eng_rd_ack", 8'h00, {7'h00, eng_rd_ack});
                hold = 1'b0;
            end
            while (eng_rd_ack !== 1'b1)
                @(negedge ref_clk);
        end
        @(posedge ref_clk);
        eng_rd_req <= 1'b0;
        while (pidx < 24)
            @(negedge ref_clk);
        test_done;
    end
endmodule // testbench
